// *** common/drs_pkg.sv ***
// package: timing constants and states for the display reset sequencer
// Functional notes
// [RULE1] host holds reset low at least 10 us
// [RULE2] ignore under 5 us, reset over 10 us
// [RULE3] 5 to 10 us pulses may reset
// [RULE4] sleep-in reset completes within 5 ms
// [RULE5] sleep-out reset completes within 120 ms
// [RULE6] blank display during reset, then defaults
// [RULE7] latch module version id within 5 ms
// [RULE8] spike rejection during valid reset pulse
// [RULE9] host waits 5 ms before commands
// [RULE10] host waits 120 ms before sleep-out
// [RULE11] synchronise input, count low pulse width
package drs_pkg;
	localparam int CLK_HZ                = 10_000_000;
	localparam int REJECT_US             = 5;
	localparam int MIN_WIDTH_US          = 10;
	localparam int SETTLE_IN_MS          = 5;
	localparam int SETTLE_OUT_MS         = 120;
	localparam int ID_LOAD_MS            = 5;
	localparam int GLITCH_NS             = 300;
	localparam int REJECT_CYC            = (REJECT_US * (CLK_HZ / 1_000_000));
	localparam int MIN_WIDTH_CYC         = (MIN_WIDTH_US * (CLK_HZ / 1_000_000));
	localparam int ACCEPT_CYC            = (REJECT_CYC + MIN_WIDTH_CYC) / 2;
	localparam int GLITCH_CYC            = (GLITCH_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int SETTLE_IN_CYC         = SETTLE_IN_MS * (CLK_HZ / 1000);
	localparam int SETTLE_OUT_CYC        = SETTLE_OUT_MS * (CLK_HZ / 1000);
	localparam int ID_LOAD_CYC           = ID_LOAD_MS * (CLK_HZ / 1000);
	localparam int HOLD_LOW_CYC          = MIN_WIDTH_CYC + 2;
	localparam int CMD_WAIT_CYC          = SETTLE_IN_CYC + 1;
	localparam int SLPOUT_WAIT_CYC       = SETTLE_OUT_CYC + 1;
	localparam int ID_LOAD_DELAY_CYC     = 16;
	localparam int CNT_W                 = 21;
	localparam logic [6:0] ID_RESET      = 7'h00;
	// arbitrary neutral id value
	localparam logic [6:0] ID_DEFAULT    = 7'h2A;
	typedef enum {ST_RUN, ST_LOW, ST_BLANK, ST_SETTLE} drs_dev_e;
	typedef enum {HS_IDLE, HS_HOLD, HS_WAIT} drs_host_e;
endpackage

// *** common/drs_if.sv ***
// interface: reset line and status between host and display driver
`timescale 1ns/1ns
`default_nettype none
interface drs_if;
	logic       ext_reset_low;
	logic       sleep_out_mode;
	logic       device_ready;
	modport device (input ext_reset_low, input sleep_out_mode, output device_ready);
	modport host   (output ext_reset_low, output sleep_out_mode, input device_ready);
endinterface
`default_nettype wire

// *** design/drs_device.sv ***
// display driver end: glitch filter, reset detection, blanking and id latch
`timescale 1ns/1ns
`default_nettype none
module drs_device #(
	parameter int SETTLE_IN_CYC  = drs_pkg::SETTLE_IN_CYC,
	parameter int SETTLE_OUT_CYC = drs_pkg::SETTLE_OUT_CYC,
	parameter int ID_LOAD_CYC    = drs_pkg::ID_LOAD_CYC
) (
	// clock and power-on reset
	input  wire logic       REF_CLK_IN,
	input  wire logic       RST_N_IN,
	// link to host
	drs_if.device           link,
	// one-time-programmable id value
	input  wire logic [6:0] OTP_ID_IN,
	// status
	output logic            BLANK_OUT,
	output logic            IN_RESET_OUT,
	output logic            ID_VALID_OUT,
	output logic [6:0]      MODULE_VERSION_ID_OUT
);
	logic                         sync_a;
	logic                         sync_b;
	logic                         filt;
	logic [7:0]                   glitch_cnt;
	logic [drs_pkg::CNT_W-1:0]    cnt;
	logic                         slp_out;
	logic                         ready;
	drs_pkg::drs_dev_e            state;

	wire  settle_lim_hit;
	wire  glitch_done;
	wire  id_hit;
	wire  [drs_pkg::CNT_W-1:0] settle_lim;
	wire                       in_run;
	wire                       in_low;
	wire                       in_settle;
	wire                       width_short;
	wire                       low_start;
	wire                       accept;
	wire                       settle_done;
	wire                       id_load;
	logic [drs_pkg::CNT_W-1:0] next_cnt;
	drs_pkg::drs_dev_e         next_state;

	// id taken early in the settle window, never past its load bound
	localparam int ID_AT = (drs_pkg::ID_LOAD_DELAY_CYC < ID_LOAD_CYC) ? drs_pkg::ID_LOAD_DELAY_CYC : ID_LOAD_CYC - 1;

	////////////////////////////////////////////////////////////////
	// two-stage synchroniser, sync_a read only by sync_b
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			sync_a <= 1'b1;
			sync_b <= 1'b1;
		end else begin
			sync_a <= link.ext_reset_low; // RULE11
			sync_b <= sync_a;
		end
	end

	// short spikes on either level never change the filtered line
	assign glitch_done = (glitch_cnt >= 8'(drs_pkg::GLITCH_CYC));
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			filt       <= 1'b1;
			glitch_cnt <= 8'h00;
		end else if (sync_b == filt) begin
			glitch_cnt <= 8'h00;
		end else if (glitch_done) begin
			filt       <= sync_b; // RULE8
			glitch_cnt <= 8'h00;
		end else begin
			glitch_cnt <= glitch_cnt + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////
	// state and counter decode
	assign in_run         = (state == drs_pkg::ST_RUN);
	assign in_low         = (state == drs_pkg::ST_LOW);
	assign in_settle      = (state == drs_pkg::ST_SETTLE);
	assign settle_lim     = slp_out ? drs_pkg::CNT_W'(SETTLE_OUT_CYC) : drs_pkg::CNT_W'(SETTLE_IN_CYC);
	assign settle_lim_hit = (cnt >= settle_lim - drs_pkg::CNT_W'(1));
	assign id_hit         = (cnt == drs_pkg::CNT_W'(ID_AT));
	assign width_short    = (cnt < drs_pkg::CNT_W'(drs_pkg::ACCEPT_CYC));
	assign low_start      = in_run && !filt;
	assign accept         = in_low && !filt && !width_short; // RULE3
	assign settle_done    = in_settle && filt && settle_lim_hit; // RULE4 RULE5
	assign id_load        = in_settle && id_hit; // RULE7

	// every transition in one place, flops below stay trivial
	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		unique case (state)
			drs_pkg::ST_RUN: begin
				if (!filt) begin
					next_state = drs_pkg::ST_LOW;
					next_cnt   = '0;
				end
			end
			drs_pkg::ST_LOW: begin
				// width counted from the filtered edge
				if (filt) begin
					next_state = drs_pkg::ST_RUN; // RULE2
				end else if (width_short) begin
					next_cnt = cnt + drs_pkg::CNT_W'(1); // RULE11
				end else begin
					// accepted between 5 and 10 us, fixed at the midpoint
					next_state = drs_pkg::ST_BLANK; // RULE3
				end
			end
			drs_pkg::ST_BLANK: begin
				next_cnt = '0;
				if (filt) begin
					next_state = drs_pkg::ST_SETTLE;
				end
			end
			drs_pkg::ST_SETTLE: begin
				next_cnt = cnt + drs_pkg::CNT_W'(1);
				if (!filt) begin
					next_state = drs_pkg::ST_BLANK;
				end else if (settle_lim_hit) begin
					next_state = drs_pkg::ST_RUN; // RULE4 RULE5
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			state <= drs_pkg::ST_SETTLE;
			cnt   <= '0;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
		end
	end

	// mode frozen at the start of the low pulse, a later change cannot stretch the settle
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			slp_out <= 1'b0;
		end else if (low_start) begin
			slp_out <= link.sleep_out_mode;
		end else if (settle_done) begin
			slp_out <= 1'b0;
		end
	end

	// blank from accept; in sleep-in and sleep-out alike blanking ends with the settle
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			BLANK_OUT <= 1'b1;
		end else if (accept) begin
			BLANK_OUT <= 1'b1; // RULE6
		end else if (settle_done) begin
			BLANK_OUT <= 1'b0; // RULE6
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			IN_RESET_OUT <= 1'b1;
		end else if (accept) begin
			IN_RESET_OUT <= 1'b1;
		end else if (settle_done) begin
			IN_RESET_OUT <= 1'b0;
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ready <= 1'b0;
		end else if (accept) begin
			ready <= 1'b0;
		end else if (settle_done) begin
			ready <= 1'b1;
		end
	end

	// a rejected pulse leaves the latched id valid
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ID_VALID_OUT <= 1'b0;
		end else if (accept) begin
			ID_VALID_OUT <= 1'b0;
		end else if (id_load) begin
			ID_VALID_OUT <= 1'b1; // RULE7
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			MODULE_VERSION_ID_OUT <= drs_pkg::ID_RESET;
		end else if (id_load) begin
			MODULE_VERSION_ID_OUT <= OTP_ID_IN; // RULE7
		end
	end

	assign link.device_ready = ready;
endmodule
`default_nettype wire

// *** design/drs_host.sv ***
// host end: drives the reset pulse and enforces post-release waits
`timescale 1ns/1ns
`default_nettype none
module drs_host #(
	parameter int CMD_WAIT_CYC    = drs_pkg::CMD_WAIT_CYC,
	parameter int SLPOUT_WAIT_CYC = drs_pkg::SLPOUT_WAIT_CYC
) (
	// clock and reset
	input  wire logic REF_CLK_IN,
	input  wire logic RST_N_IN,
	// user side
	input  wire logic RESET_REQ_IN,
	input  wire logic SLEEP_OUT_MODE_IN,
	// link to device
	drs_if.host       link,
	// status
	output logic      BUSY_OUT,
	output logic      CMD_OK_OUT,
	output logic      SLPOUT_OK_OUT
);
	logic [drs_pkg::CNT_W-1:0] cnt;
	logic                      rst_low;
	logic                      mode;
	drs_pkg::drs_host_e        state;

	wire hold_done;
	wire cmd_hit;
	wire slp_hit;

	assign hold_done = (cnt >= drs_pkg::CNT_W'(drs_pkg::HOLD_LOW_CYC - 1));
	assign cmd_hit   = (cnt >= drs_pkg::CNT_W'(CMD_WAIT_CYC - 1));
	assign slp_hit   = (cnt >= drs_pkg::CNT_W'(SLPOUT_WAIT_CYC - 1));

	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			state         <= drs_pkg::HS_IDLE;
			cnt           <= '0;
			rst_low       <= 1'b1;
			mode          <= 1'b0;
			BUSY_OUT      <= 1'b0;
			CMD_OK_OUT    <= 1'b0;
			SLPOUT_OK_OUT <= 1'b0;
		end else begin
			mode <= SLEEP_OUT_MODE_IN;
			unique case (state)
				drs_pkg::HS_IDLE: begin
					if (RESET_REQ_IN) begin
						state         <= drs_pkg::HS_HOLD;
						cnt           <= '0;
						rst_low       <= 1'b0;
						BUSY_OUT      <= 1'b1;
						CMD_OK_OUT    <= 1'b0;
						SLPOUT_OK_OUT <= 1'b0;
					end
				end
				drs_pkg::HS_HOLD: begin
					cnt <= cnt + drs_pkg::CNT_W'(1);
					if (hold_done) begin
						state   <= drs_pkg::HS_WAIT; // RULE1 RULE3
						rst_low <= 1'b1;
						cnt     <= '0;
					end
				end
				drs_pkg::HS_WAIT: begin
					cnt <= cnt + drs_pkg::CNT_W'(1);
					if (cmd_hit) begin
						CMD_OK_OUT <= 1'b1; // RULE9
					end
					if (slp_hit) begin
						SLPOUT_OK_OUT <= 1'b1; // RULE10
						BUSY_OUT      <= 1'b0;
						state         <= drs_pkg::HS_IDLE;
					end
				end
			endcase
		end
	end

	assign link.ext_reset_low  = rst_low;
	assign link.sleep_out_mode = mode;
endmodule
`default_nettype wire

// *** tb/drs_props.sv ***
// assertions on the host to device reset link
`timescale 1ns/1ns
`default_nettype none
module drs_props (
	input wire logic REF_CLK_IN,
	input wire logic RST_N_IN,
	input wire logic ext_reset_low,
	input wire logic sleep_out_mode,
	input wire logic device_ready
);
	// bounds hold settle parameters of 200 and 400 plus filter lag
	localparam int IN_MAX  = 215;
	localparam int OUT_MAX = 415;
	int            low_cnt;
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
		if (!RST_N_IN)
			low_cnt <= 0;
		else
			low_cnt <= ext_reset_low ? 0 : low_cnt + 1;
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	////////////////////////////////////////////////////////////////
	chk_low_min: assert property ($rose(ext_reset_low) |-> $past(low_cnt) >= 99)
		else $error("reset pulse too short");
	chk_low_clean: assert property ($fell(ext_reset_low) |-> !ext_reset_low [*8])
		else $error("reset pulse broken early");
	chk_blank_by: assert property ($fell(ext_reset_low) |-> ##[1:100] !device_ready)
		else $error("device not in reset");
	chk_ready_fall: assert property ($fell(device_ready) |-> $past(low_cnt) >= 50)
		else $error("short pulse accepted");
	chk_ready_line: assert property ($rose(device_ready) |-> ext_reset_low)
		else $error("ready while line low");
	chk_settle_gap: assert property ($rose(ext_reset_low) |-> !device_ready [*8])
		else $error("ready without settle");
	chk_settle_in: assert property ($rose(ext_reset_low) && !sleep_out_mode |-> ##[1:IN_MAX] device_ready)
		else $error("sleep-in settle late");
	chk_settle_out: assert property ($rose(ext_reset_low) && sleep_out_mode |-> ##[1:OUT_MAX] device_ready)
		else $error("sleep-out settle late");
endmodule
`default_nettype wire

// *** tb/drs_tb.sv ***
// self-checking bench for both reset sequencer ends
`timescale 1ns/1ns
`default_nettype none
module drs_tb;
	logic       clk = 0;
	logic       rst_n = 0;
	logic       req = 0;
	logic       mode = 0;
	logic       rdy_d = 0;
	logic [6:0] otp = 7'h00;
	logic [6:0] otp2 = 7'h55;
	logic [6:0] last2 = 7'h55;
	logic [6:0] id, id2;
	logic       blank, in_rst, id_ok, busy, cmd_ok, slp_ok, blank2, in_rst2, id_ok2;
	logic [8:0] exp_q[$];
	int         n_errors = 0;
	int         samples_checked = 0;
	int         k, t, tc;
	drs_if      link_a();
	drs_if      link_b();
	wire [4:0]  sel = {cmd_ok, link_a.ext_reset_low, link_b.device_ready, !busy, link_a.device_ready};
	always #50 clk = ~clk;
	////////////////////////////////////////////////////////////////
	drs_host #(.CMD_WAIT_CYC(201), .SLPOUT_WAIT_CYC(401)) drs_host_i (.REF_CLK_IN(clk), .RST_N_IN(rst_n),
		.RESET_REQ_IN(req), .SLEEP_OUT_MODE_IN(mode), .link(link_a), .BUSY_OUT(busy), .CMD_OK_OUT(cmd_ok),
		.SLPOUT_OK_OUT(slp_ok));
	drs_device #(.SETTLE_IN_CYC(200), .SETTLE_OUT_CYC(400)) drs_device_i (.REF_CLK_IN(clk),
		.RST_N_IN(rst_n), .link(link_a), .OTP_ID_IN(otp), .BLANK_OUT(blank), .IN_RESET_OUT(in_rst),
		.ID_VALID_OUT(id_ok), .MODULE_VERSION_ID_OUT(id));
	// second device faces the bench, which breaks the pulse rules on purpose
	// only sleep-in pulses reach it, so the sleep-out settle keeps its default
	drs_device #(.SETTLE_IN_CYC(200)) drs_device_i2 (.REF_CLK_IN(clk),
		.RST_N_IN(rst_n), .link(link_b), .OTP_ID_IN(otp2), .BLANK_OUT(blank2), .IN_RESET_OUT(in_rst2),
		.ID_VALID_OUT(id_ok2), .MODULE_VERSION_ID_OUT(id2));
	drs_props drs_props_i (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .ext_reset_low(link_a.ext_reset_low),
		.sleep_out_mode(link_a.sleep_out_mode), .device_ready(link_a.device_ready));
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [8:0] seen, input logic [8:0] want);
		samples_checked++;
		if (seen !== want) begin
			n_errors++;
			$display("unexpected at %0t: seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wait_hi(input int w);
		for (t = 0; t < 3000; t++) begin
			@(negedge clk);
			if (sel[w] === 1'b1)
				return;
		end
		n_errors++;
		final_report();
	endtask
	// oldest note is matched on each new ready
	always @(negedge clk) begin
		if (link_a.device_ready && !rdy_d && exp_q.size() > 0)
			check({id_ok, id, blank}, exp_q.pop_front());
		rdy_d <= link_a.device_ready;
	end
	////////////////////////////////////////////////////////////////
	initial begin
		link_b.ext_reset_low = 1'b1;
		link_b.sleep_out_mode = 1'b0;
		void'($urandom(32'h30B8));
		repeat (6) @(negedge clk);
		rst_n = 1;
		wait_hi(2);
		for (k = 0; k < 4; k++) begin
			otp = 7'($urandom);
			mode = k[0];
			@(negedge clk);
			req = 1;
			@(negedge clk);
			req = 0;
			exp_q.push_back({1'b1, otp, 1'b0});
			@(negedge clk);
			wait_hi(3);
			check({7'h00, in_rst, blank}, 9'h003);
			wait_hi(4);
			tc = t;
			check(9'(tc >= 199), 9'h001);
			check({8'h00, slp_ok}, 9'h000);
			wait_hi(1);
			check(9'(tc + t >= 398), 9'h001);
			check({8'h00, slp_ok}, 9'h001);
			wait_hi(0);
		end
		// glitch, too short, and long with a spike inside
		for (k = 0; k < 3; k++) begin
			otp2 = 7'($urandom);
			link_b.ext_reset_low = 1'b0;
			repeat (k == 0 ? 3 : k == 1 ? 40 : 60) @(negedge clk);
			if (k == 2) begin
				link_b.ext_reset_low = 1'b1;
				repeat (2) @(negedge clk);
				link_b.ext_reset_low = 1'b0;
				repeat (60) @(negedge clk);
			end
			link_b.ext_reset_low = 1'b1;
			repeat (20) @(negedge clk);
			check({8'h00, in_rst2}, 9'(k == 2));
			if (k == 2) begin
				wait_hi(2);
				last2 = otp2;
			end
			check({id_ok2, id2, blank2}, {1'b1, last2, 1'b0});
		end
		final_report();
	end
endmodule
`default_nettype wire
